// ==== design/glw_host_writer.sv ====
`timescale 1ns/1ps
`include "glw_consts.svh"
//  Function
// - Drive enable, read/write, register select outputs
// - Hold data and selects through enable fall
// - Drive bus on writes, release on reads
// - Instruction write then data write, paired
// - First init pair: 00 then 32
// - Then 01 with 07, 8-bit data
// - Then 02 with 1D, line bytes
// - Then 03 with 1F, 1/32 duty
// - Then 04 with zero, cursor hidden
// - Then 08 and 09 with zero
// - Finish with 0A and 0B zero
// - Clear writes 00 into every byte
// - Clear allowed only after initialisation
// - Outputs configured before any transfer
// - Sample read data only while driven
// - Poll busy flag before each pair
// - Select and drive, then strobe, strobe low ordering
// - Clear writes exactly 1920 bytes
module glw_host_writer #(
	parameter int STROBE_CYC = `GLW_STROBE_CYC,
	parameter int SETUP_CYC  = `GLW_SETUP_CYC
) (
	input  wire logic        pclk,          // Bus clock
	input  wire logic        presetn,       // Async reset, active low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB enable
	input  wire logic        pwrite,        // APB direction
	input  wire logic [11:0] paddr,         // APB address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic      [31:0] prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error
	output logic             lcd_enable,    // Enable strobe, high active
	output logic             lcd_read,      // High read, low write
	output logic             register_select, // High instruction, low data
	input  wire logic [7:0]  lcd_bus_in,    // Data bus input
	output logic      [7:0]  lcd_bus_out,   // Data bus output
	output logic      [7:0]  lcd_bus_oe     // Data bus drive enable
);
	import glw_pkg::*;

	localparam logic [7:0] CNT_SETUP  = 8'(SETUP_CYC);
	localparam logic [7:0] CNT_STROBE = 8'(STROBE_CYC);

	glw_state_type state_reg;
	glw_op_type    op_reg;
	logic [7:0]  cnt_reg;
	logic        phase_reg;     // 0 instruction, 1 data
	logic [3:0]  idx_reg;
	logic [15:0] fill_reg;
	logic        inited_reg;
	logic        reject_reg;
	logic        poll_only_reg;
	logic [7:0]  instr_reg;
	logic [7:0]  data_reg;
	logic [7:0]  rd_reg;
	logic [7:0]  rom_code;
	logic [7:0]  rom_param;
	logic [7:0]  cur_code;
	logic [7:0]  cur_param;

	glw_init_rom u_rom (
		.idx   (idx_reg),
		.code  (rom_code),
		.param (rom_param)
	);

	// Clear sequence: cursor lo, cursor hi, then data bursts
	always_comb begin
		cur_code  = instr_reg;
		cur_param = data_reg;
		unique case (op_reg)
			GLW_OP_INIT: begin
				cur_code  = rom_code;
				cur_param = rom_param;
			end
			GLW_OP_CLEAR: begin
				if (idx_reg == 4'h0) begin
					cur_code = `GLW_CURSOR_LO_CODE;
				end else if (idx_reg == 4'h1) begin
					cur_code = `GLW_CURSOR_HI_CODE;
				end else begin
					cur_code = `GLW_DATA_WRITE_CODE;
				end
				cur_param = `GLW_CLEAR_VALUE;
			end
			GLW_OP_PAIR, GLW_OP_NONE: begin
				cur_code  = instr_reg;
				cur_param = data_reg;
			end
		endcase
	end

	wire logic apb_wr = psel && penable && pwrite;
	wire logic busy   = (state_reg != GLW_IDLE);

	// APB answers in the access phase, zero wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`GLW_STAT_ADDR:   prdata <= {29'h0, reject_reg, inited_reg, busy};
					`GLW_INSTR_ADDR:  prdata <= {24'h0, instr_reg};
					`GLW_DATA_ADDR:   prdata <= {24'h0, data_reg};
					`GLW_RDDATA_ADDR: prdata <= {24'h0, rd_reg};
					`GLW_CTRL_ADDR:   prdata <= 32'h0000_0000;
					default: pslverr <= 1'b1;
				endcase
			end else if (psel && !penable) begin
				unique case (paddr)
					`GLW_CTRL_ADDR, `GLW_INSTR_ADDR, `GLW_DATA_ADDR: pslverr <= 1'b0;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	wire logic acc_wr   = apb_wr && pready;
	wire logic ctl_wr   = acc_wr && (paddr == `GLW_CTRL_ADDR) && !busy;
	wire logic go_init  = ctl_wr && pwdata[`GLW_CTRL_INIT_BIT];
	wire logic go_clear = ctl_wr && !pwdata[`GLW_CTRL_INIT_BIT] && pwdata[`GLW_CTRL_CLEAR_BIT];
	wire logic go_pair  = ctl_wr && !pwdata[`GLW_CTRL_INIT_BIT] && !pwdata[`GLW_CTRL_CLEAR_BIT]
		&& pwdata[`GLW_CTRL_PAIR_BIT];
	wire logic go_read  = ctl_wr && pwdata[3:0] == 4'h8;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_reg <= 8'h00;
			data_reg  <= 8'h00;
		end else if (acc_wr && !busy) begin
			if (paddr == `GLW_INSTR_ADDR) instr_reg <= pwdata[7:0];
			if (paddr == `GLW_DATA_ADDR)  data_reg  <= pwdata[7:0];
		end
	end

	// Clear before init is refused and flagged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reject_reg <= 1'b0;
		end else if (go_clear && !inited_reg) begin
			reject_reg <= 1'b1;
		end else if (ctl_wr) begin
			reject_reg <= 1'b0;
		end
	end

	wire logic last_step = (op_reg == GLW_OP_INIT) ? (idx_reg == `GLW_INIT_LEN - 4'h1)
		: (op_reg == GLW_OP_CLEAR) ? (idx_reg == 4'h2 && fill_reg == 16'h0001)
		: 1'b1;

	// Sequencer: poll busy, then instruction phase, then data phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg     <= GLW_IDLE;
			op_reg        <= GLW_OP_NONE;
			cnt_reg       <= 8'h00;
			phase_reg     <= 1'b0;
			idx_reg       <= 4'h0;
			fill_reg      <= 16'h0000;
			inited_reg    <= 1'b0;
			poll_only_reg <= 1'b0;
			rd_reg        <= 8'h00;
		end else begin
			unique case (state_reg)
				GLW_IDLE: begin
					idx_reg   <= 4'h0;
					phase_reg <= 1'b0;
					cnt_reg   <= CNT_SETUP;
					fill_reg  <= `GLW_CLEAR_BYTES;
					poll_only_reg <= go_read;
					if (go_init) begin
						op_reg    <= GLW_OP_INIT;
						state_reg <= GLW_POLL;
					end else if (go_clear && inited_reg) begin
						op_reg    <= GLW_OP_CLEAR;
						state_reg <= GLW_POLL;
					end else if (go_pair || go_read) begin
						op_reg    <= GLW_OP_PAIR;
						state_reg <= GLW_POLL;
					end
				end
				GLW_POLL: begin
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else begin
						state_reg <= GLW_RDONE;
						cnt_reg   <= CNT_STROBE;
					end
				end
				GLW_RDONE: begin
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else begin
						rd_reg <= lcd_bus_in;
						cnt_reg <= CNT_SETUP;
						if (poll_only_reg) begin
							state_reg <= GLW_IDLE;
							op_reg    <= GLW_OP_NONE;
						end else if (lcd_bus_in[`GLW_LCD_BUSY_BIT]) begin
							state_reg <= GLW_POLL;
						end else begin
							state_reg <= GLW_SETUP;
						end
					end
				end
				GLW_SETUP: begin
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else begin
						state_reg <= GLW_STROBE;
						cnt_reg   <= CNT_STROBE;
					end
				end
				GLW_STROBE: begin
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else begin
						state_reg <= GLW_HOLD;
						cnt_reg   <= CNT_SETUP;
					end
				end
				GLW_HOLD: begin
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else if (!phase_reg) begin
						phase_reg <= 1'b1;
						state_reg <= GLW_SETUP;
						cnt_reg   <= CNT_SETUP;
					end else begin
						state_reg <= GLW_NEXT;
					end
				end
				GLW_NEXT: begin
					phase_reg <= 1'b0;
					cnt_reg   <= CNT_SETUP;
					if (last_step) begin
						state_reg <= GLW_IDLE;
						if (op_reg == GLW_OP_INIT) inited_reg <= 1'b1;
						op_reg <= GLW_OP_NONE;
					end else begin
						state_reg <= GLW_POLL;
						if (op_reg == GLW_OP_CLEAR && idx_reg == 4'h2) begin
							fill_reg <= fill_reg - 16'h0001;
						end else begin
							idx_reg <= idx_reg + 4'h1;
						end
					end
				end
				default: state_reg <= GLW_IDLE;
			endcase
		end
	end

	// Pin drive: bus released only during busy polls and reads, driven otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcd_enable      <= 1'b0;
			lcd_read        <= 1'b0;
			register_select <= 1'b0;
			lcd_bus_out     <= 8'h00;
			lcd_bus_oe      <= 8'hFF;
		end else begin
			lcd_enable <= (state_reg == GLW_STROBE) || (state_reg == GLW_RDONE && cnt_reg != 8'h00);
			if (state_reg == GLW_POLL || state_reg == GLW_RDONE) begin
				lcd_read        <= 1'b1;
				register_select <= 1'b1;
				lcd_bus_oe      <= 8'h00;
			end else if (state_reg == GLW_SETUP || state_reg == GLW_STROBE || state_reg == GLW_HOLD) begin
				lcd_read        <= 1'b0;
				register_select <= !phase_reg;
				lcd_bus_oe      <= 8'hFF;
				lcd_bus_out     <= phase_reg ? cur_param : cur_code;
			end else begin
				lcd_read   <= 1'b0;
				lcd_bus_oe <= 8'hFF;
			end
		end
	end

	localparam int STROBE_HI = STROBE_CYC;

	// Counts init pairs so completion can be held against the table length
	logic [3:0] init_pairs_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_pairs_reg <= 4'h0;
		end else if (op_reg == GLW_OP_INIT && state_reg == GLW_NEXT) begin
			init_pairs_reg <= init_pairs_reg + 4'h1;
		end
	end

	sequence write_rise_s;
		$rose(lcd_enable) && !lcd_read;
	endsequence

	sequence write_pulse_s;
		##STROBE_HI lcd_enable ##1 !lcd_enable;
	endsequence

	write_rw_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(lcd_enable && lcd_bus_oe == 8'hFF) |-> !lcd_read)
		else $error("read/write high during a write strobe");
	poll_released_a: assert property (@(posedge pclk) disable iff (!presetn)
		lcd_read |-> lcd_bus_oe == 8'h00)
		else $error("bus driven during a read");
	hold_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		($fell(lcd_enable) && !lcd_read) |-> $stable(lcd_bus_out) && $stable(register_select))
		else $error("data moved at strobe fall");
	clear_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == GLW_POLL && op_reg == GLW_OP_CLEAR) |-> inited_reg)
		else $error("clear ran before init");
	clear_value_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op_reg == GLW_OP_CLEAR && state_reg == GLW_STROBE && phase_reg) |-> lcd_bus_out == 8'h00)
		else $error("clear wrote a nonzero byte");
	first_init_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op_reg == GLW_OP_INIT && idx_reg == 4'h0 && state_reg == GLW_STROBE)
			|-> lcd_bus_out == (phase_reg ? 8'h32 : 8'h00))
		else $error("first init pair wrong");
	poll_first_a: assert property (@(posedge pclk) disable iff (!presetn)
		($past(state_reg) == GLW_IDLE && state_reg != GLW_IDLE) |-> state_reg == GLW_POLL)
		else $error("pair started without busy poll");
	pair_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == GLW_HOLD && !phase_reg && cnt_reg == 8'h00) |=> state_reg == GLW_SETUP && phase_reg)
		else $error("data write did not follow instruction");
	strobe_width_a: assert property (@(posedge pclk) disable iff (!presetn)
		write_rise_s |-> write_pulse_s)
		else $error("write strobe width wrong");
	setup_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		write_rise_s |-> $stable(lcd_bus_out) && $stable(register_select) && lcd_bus_oe == 8'hFF)
		else $error("lines not settled before strobe");
	sample_window_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == GLW_RDONE && cnt_reg == 8'h00) |-> lcd_enable && lcd_read && lcd_bus_oe == 8'h00)
		else $error("read sampled outside strobe");
	init_count_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(inited_reg) |-> init_pairs_reg == `GLW_INIT_LEN)
		else $error("init ended with wrong pair count");
endmodule // glw_host_writer

// ==== design/glw_consts.svh ====
`ifndef GLW_CONSTS_SVH
`define GLW_CONSTS_SVH

// Register map (byte addresses)
`define GLW_CTRL_ADDR     12'h000
`define GLW_STAT_ADDR     12'h004
`define GLW_INSTR_ADDR    12'h008
`define GLW_DATA_ADDR     12'h00C
`define GLW_RDDATA_ADDR   12'h010

// Control register bits
`define GLW_CTRL_INIT_BIT  0
`define GLW_CTRL_CLEAR_BIT 1
`define GLW_CTRL_PAIR_BIT  2
`define GLW_CTRL_READ_BIT  3

// Status register bits
`define GLW_STAT_BUSY_BIT  0
`define GLW_STAT_INIT_BIT  1
`define GLW_STAT_REJ_BIT   2

// Controller busy flag position in status byte
`define GLW_LCD_BUSY_BIT   7

// Init table length and clear constants
`define GLW_INIT_LEN       4'h9
`define GLW_CLEAR_BYTES    16'h0780
`define GLW_CLEAR_VALUE    8'h00
`define GLW_CURSOR_LO_CODE 8'h0A
`define GLW_CURSOR_HI_CODE 8'h0B
`define GLW_DATA_WRITE_CODE 8'h0C

// Strobe timing: enable high at least 450 ns, setup 140 ns
`define GLW_STROBE_NS      450
`define GLW_SETUP_NS       140
`define GLW_CLK_NS         5
`define GLW_STROBE_CYC     ((`GLW_STROBE_NS + `GLW_CLK_NS - 1) / `GLW_CLK_NS)
`define GLW_SETUP_CYC      ((`GLW_SETUP_NS + `GLW_CLK_NS - 1) / `GLW_CLK_NS)

`endif

// ==== design/glw_pkg.sv ====
package glw_pkg;
	typedef enum logic [6:0] {
		GLW_IDLE   = 7'h01,
		GLW_POLL   = 7'h02,
		GLW_SETUP  = 7'h04,
		GLW_STROBE = 7'h08,
		GLW_HOLD   = 7'h10,
		GLW_NEXT   = 7'h20,
		GLW_RDONE  = 7'h40
	} glw_state_type;

	typedef enum logic [1:0] {
		GLW_OP_NONE  = 2'h0,
		GLW_OP_INIT  = 2'h1,
		GLW_OP_CLEAR = 2'h2,
		GLW_OP_PAIR  = 2'h3
	} glw_op_type;
endpackage

// ==== design/glw_init_rom.sv ====
`timescale 1ns/1ps
`include "glw_consts.svh"
module glw_init_rom (
	input  wire logic [3:0] idx,   // Table entry
	output logic      [7:0] code,  // Instruction code
	output logic      [7:0] param  // Parameter byte
);
	always_comb begin
		code  = 8'h00;
		param = 8'h00;
		unique case (idx)
			4'h0: begin code = 8'h00; param = 8'h32; end
			4'h1: begin code = 8'h01; param = 8'h07; end
			4'h2: begin code = 8'h02; param = 8'h1D; end
			4'h3: begin code = 8'h03; param = 8'h1F; end
			4'h4: begin code = 8'h04; param = 8'h00; end
			4'h5: begin code = 8'h08; param = 8'h00; end
			4'h6: begin code = 8'h09; param = 8'h00; end
			4'h7: begin code = `GLW_CURSOR_LO_CODE; param = 8'h00; end
			4'h8: begin code = `GLW_CURSOR_HI_CODE; param = 8'h00; end
			default: begin code = 8'h00; param = 8'h00; end
		endcase
	end
endmodule // glw_init_rom

// ==== tb/glw_lcd_model.sv ====
`timescale 1ns/1ps
`include "glw_consts.svh"
module glw_lcd_model (
	input  wire logic       pclk,            // Host clock
	input  wire logic       presetn,         // Async reset, active low
	input  wire logic       lcd_enable,      // Enable strobe
	input  wire logic       lcd_read,        // High read
	input  wire logic       register_select, // High instruction
	input  wire logic [7:0] lcd_bus_out,     // Host drive value
	input  wire logic [7:0] lcd_bus_oe,      // Host drive enable
	input  wire logic [1:0] busy_polls,      // Busy answers after a pair
	output logic      [7:0] lcd_bus_in,      // Controller drive value
	output logic            pair_valid,      // Pair committed
	output logic      [7:0] pair_code,       // Instruction of pair
	output logic      [7:0] pair_param,      // Data of pair
	output logic            fault            // Sticky protocol fault
);
	logic        en_reg;
	logic [1:0]  busy_reg;
	logic [7:0]  last_reg;
	logic [7:0]  code_reg;
	logic [7:0]  bus_reg;
	logic        sel_reg;
	logic [15:0] cursor_reg;
	// Undriven bus shows the inverse of the last value, never a stale copy
	assign lcd_bus_in = (lcd_read && lcd_enable) ? {busy_reg != 2'h0, 7'h15} : ~last_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= 1'b0;
			busy_reg <= 2'h0;
			last_reg <= 8'h00;
			code_reg <= 8'h00;
			bus_reg <= 8'h00;
			sel_reg <= 1'b0;
			cursor_reg <= 16'h0000;
			pair_valid <= 1'b0;
			pair_code <= 8'h00;
			pair_param <= 8'h00;
			fault <= 1'b0;
		end else begin
			en_reg <= lcd_enable;
			bus_reg <= lcd_bus_out;
			sel_reg <= register_select;
			last_reg <= lcd_bus_in;
			pair_valid <= 1'b0;
			if (lcd_enable && lcd_read && lcd_bus_oe != 8'h00)
				fault <= 1'b1;
			if (lcd_enable && !lcd_read && lcd_bus_oe != 8'hFF)
				fault <= 1'b1;
			// Write is committed on the strobe fall, so lines must hold through it
			if (en_reg && !lcd_read && (bus_reg != lcd_bus_out || sel_reg != register_select))
				fault <= 1'b1;
			if (en_reg && !lcd_enable && !lcd_read) begin
				if (register_select)
					code_reg <= lcd_bus_out;
				else begin
					pair_valid <= 1'b1;
					pair_code <= code_reg;
					pair_param <= lcd_bus_out;
					busy_reg <= busy_polls;
					if (code_reg == `GLW_CURSOR_LO_CODE)
						cursor_reg[7:0] <= lcd_bus_out;
					else if (code_reg == `GLW_CURSOR_HI_CODE)
						cursor_reg[15:8] <= lcd_bus_out;
					else if (code_reg == `GLW_DATA_WRITE_CODE)
						cursor_reg <= cursor_reg + 16'h0001;
				end
			end
			if (en_reg && !lcd_enable && lcd_read && busy_reg != 2'h0)
				busy_reg <= busy_reg - 2'h1;
		end
	end
endmodule // glw_lcd_model

// ==== tb/glw_host_writer_bench.sv ====
`timescale 1ns/1ps
`include "glw_consts.svh"
`define GLW_CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module glw_host_writer_bench;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        lcd_enable;
	logic        lcd_read;
	logic        register_select;
	logic [7:0]  lcd_bus_in;
	logic [7:0]  lcd_bus_out;
	logic [7:0]  lcd_bus_oe;
	logic [1:0]  busy_polls;
	logic        pair_valid;
	logic [7:0]  pair_code;
	logic [7:0]  pair_param;
	logic        fault;
	logic [31:0] rd;
	logic        er;
	logic [31:0] seed;
	logic [15:0] exp_q[$];
	logic [15:0] e;
	int          mismatches;
	int          total_checks;
	logic [15:0] init_tab [9] = '{16'h0032, 16'h0107, 16'h021D, 16'h031F, 16'h0400,
		16'h0800, 16'h0900, 16'h0A00, 16'h0B00};

	glw_host_writer #(.STROBE_CYC(2), .SETUP_CYC(1)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lcd_enable(lcd_enable), .lcd_read(lcd_read),
		.register_select(register_select), .lcd_bus_in(lcd_bus_in), .lcd_bus_out(lcd_bus_out),
		.lcd_bus_oe(lcd_bus_oe));
	glw_lcd_model lcd (.pclk(pclk), .presetn(presetn), .lcd_enable(lcd_enable), .lcd_read(lcd_read),
		.register_select(register_select), .lcd_bus_out(lcd_bus_out), .lcd_bus_oe(lcd_bus_oe),
		.busy_polls(busy_polls), .lcd_bus_in(lcd_bus_in), .pair_valid(pair_valid),
		.pair_code(pair_code), .pair_param(pair_param), .fault(fault));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Entered just after a rising edge; returns one edge after release
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wait_idle();
		do begin
			apb(1'b0, `GLW_STAT_ADDR, 32'h0);
		end while (rd[`GLW_STAT_BUSY_BIT] !== 1'b0);
	endtask

	task automatic run_op(input logic [31:0] ctrl);
		apb(1'b1, `GLW_CTRL_ADDR, ctrl);
		wait_idle();
	endtask

	always @(posedge pclk) begin
		if (pair_valid === 1'b1) begin
			if (exp_q.size() == 0)
				`GLW_CHK("pair_extra", 1'b0, 1'b1)
			else begin
				e = exp_q.pop_front();
				`GLW_CHK("pair", e, {pair_code, pair_param})
			end
		end
	end

	initial begin
		repeat (80000) @(posedge pclk);
		mismatches++;
		final_report();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		busy_polls = 2'h0;
		seed = 32'h0000DD09;
		mismatches = 0;
		total_checks = 0;
		repeat (5) @(posedge pclk);
		`GLW_CHK("oe_reset", 8'hFF, lcd_bus_oe)
		`GLW_CHK("enable_reset", 1'b0, lcd_enable)
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `GLW_STAT_ADDR, 32'h0);
		`GLW_CHK("stat_reset", 3'h0, rd[2:0])
		run_op(32'h8);
		apb(1'b0, `GLW_RDDATA_ADDR, 32'h0);
		`GLW_CHK("busy_read", 8'h15, rd[7:0])
		run_op(32'h2);
		`GLW_CHK("clear_refused", 1'b1, rd[`GLW_STAT_REJ_BIT])
		apb(1'b0, 12'h020, 32'h0);
		`GLW_CHK("unmapped", 1'b1, er)
		busy_polls <= 2'h3;
		foreach (init_tab[i])
			exp_q.push_back(init_tab[i]);
		run_op(32'h1);
		`GLW_CHK("inited", 1'b1, rd[`GLW_STAT_INIT_BIT])
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			busy_polls <= seed[17:16];
			apb(1'b1, `GLW_INSTR_ADDR, {24'h0, seed[7:0]});
			apb(1'b1, `GLW_DATA_ADDR, {24'h0, seed[15:8]});
			exp_q.push_back({seed[7:0], seed[15:8]});
			apb(1'b1, `GLW_CTRL_ADDR, 32'h4);
			// Written while busy, so it must be refused
			apb(1'b1, `GLW_INSTR_ADDR, {24'h0, ~seed[7:0]});
			wait_idle();
			apb(1'b0, `GLW_INSTR_ADDR, 32'h0);
			`GLW_CHK("instr_kept", seed[7:0], rd[7:0])
		end
		busy_polls <= 2'h0;
		exp_q.push_back(16'h0A00);
		exp_q.push_back(16'h0B00);
		repeat (1920)
			exp_q.push_back(16'h0C00);
		run_op(32'h2);
		`GLW_CHK("all_pairs", 1'b1, exp_q.size() == 0)
		`GLW_CHK("cursor_end", `GLW_CLEAR_BYTES, lcd.cursor_reg)
		`GLW_CHK("bus_fault", 1'b0, fault)
		final_report();
	end
endmodule // glw_host_writer_bench
